// [axis_model.sv]
module axis_model (
    input  wire logic        pclk,    // Clock.
    input  wire logic        presetn, // Reset, active low.
    input  wire logic        busy,    // Move in progress.
    input  wire logic [31:0] dest,    // Destination of the move.
    output logic      [31:0] pos      // Present axis position.
);
    timeunit 1ns;
    timeprecision 1ps;

    // The axis steps once per cycle, so every switch point and notch edge is crossed exactly once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos <= 32'h0000_0000;
        end else if (busy && pos != dest) begin
            pos <= ($signed(dest) > $signed(pos)) ? pos + 32'h0000_0001 : pos - 32'h0000_0001;
        end
    end
endmodule

// [nmp_pkg.sv]
package nmp_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFS_FRAME_LO   = 8'h00;
    localparam logic [7:0] OFS_FRAME_HI   = 8'h04;
    localparam logic [7:0] OFS_NOTCH_CFG  = 8'h08;
    localparam logic [7:0] OFS_NOTCH_LIM  = 8'h0C;
    localparam logic [7:0] OFS_STAGE_CNT  = 8'h1C;
    localparam logic [7:0] OFS_INIT_SPD   = 8'h20;
    localparam logic [7:0] OFS_STATUS     = 8'h24;
    localparam logic [7:0] OFS_DEST       = 8'h28;
    localparam logic [7:0] OFS_STAGE_POS  = 8'h40;
    localparam logic [7:0] OFS_STAGE_SPD  = 8'h80;
    // Frame field positions inside the low frame word.
    localparam int BIT_START  = 0;
    localparam int BIT_SERVO  = 1;
    localparam int POS_CODE   = 8;
    localparam int BIT_INC    = 24;
    // Notch configuration field positions.
    localparam int BIT_DESIG  = 0;
    localparam int POS_NSEL   = 4;
    // Command codes.
    localparam logic [3:0] CMD_NOTCH = 4'h3;
    localparam logic [3:0] CMD_MULTI = 4'h4;
    // Parameter ranges and reset values.
    localparam logic [26:0] STAGE_POS_MAX = 27'h5F5_E0FF;
    localparam logic [17:0] SPD_MAX       = 18'h3_A980;
    localparam logic [17:0] SPD_DEF       = 18'h0_5DC0;
    localparam logic [31:0] NOTCH_LIM_MAX = 32'h05F5_E0FF;
    localparam logic [4:0]  STAGE_CNT_DEF = 5'h00;

    // Latched move command.
    typedef struct packed {
        logic [3:0]  code;
        logic        inc;
        logic [31:0] target;
    } cmd_t;
endpackage

// [notch_multispeed_positioning.sv]
// Local design decisions: the register offsets and the APB interface to the registers.
module notch_multispeed_positioning #(
    parameter int STAGES = 16
) (
    input  wire logic        pclk,      // 200 MHz clock.
    input  wire logic        presetn,   // Asynchronous reset, active low.
    input  wire logic        ce,        // Clock enable; state frozen while low.
    input  wire logic        psel,      // APB select.
    input  wire logic        penable,   // APB enable.
    input  wire logic        pwrite,    // APB direction.
    input  wire logic [7:0]  paddr,     // APB byte address.
    input  wire logic [31:0] pwdata,    // APB write data.
    output logic             pready,    // APB ready.
    output logic [31:0]      prdata,    // APB read data.
    output logic             pslverr,   // APB error on unmapped address.
    input  wire logic [31:0] pos_in,    // Present axis position, signed steps.
    output logic [17:0]      speed_cmd, // Commanded feed speed, zero when idle.
    output logic [31:0]      dest,      // Destination of the running move.
    output logic             busy,      // Move in progress.
    output logic [1:0]       notch      // Notch outputs 2 and 1.
);
    // Stage registers are decoded from four address bits, so at most sixteen can be reached.
    if (STAGES < 1 || STAGES > 16) begin
        $error("STAGES must be 1 to 16");
    end

    // Two states suffice: hold and cancel handling are not part of this block.
    typedef enum logic {IDLE, MOVE} state_t;

    // Frame, parameter store, sequencer state and bus decode terms.
    logic [31:0]  frame_lo_r, frame_hi_r, dest_r;
    logic         desig_r;
    logic [1:0]   nsel_r, notch_r;
    logic [31:0]  nlim_r [4];
    logic [4:0]   stage_cnt_r, idx_r;
    logic [17:0]  init_spd_r, speed_r;
    logic [26:0]  stpos_r [STAGES];
    logic [17:0]  stspd_r [STAGES];
    logic         start_prev_r, pready_r, pslverr_r;
    logic [31:0]  prdata_r, start_pos_r, trav;
    nmp_pkg::cmd_t cmd_r;
    state_t       state_r;
    logic         wr, rd, start_rise, go, servo, arrived;
    logic [31:0]  rdata;
    logic         rerr;

    // One wait state: the access phase sees pready on its second cycle.
    // A write lands on the edge that ends the access, so the master has held its data through the wait.
    assign wr = psel && penable && pwrite && pready_r;
    assign rd = psel && penable && !pready_r;
    assign servo = frame_lo_r[nmp_pkg::BIT_SERVO];
    assign start_rise = frame_lo_r[nmp_pkg::BIT_START] && !start_prev_r;
    assign go = start_rise && servo && state_r == IDLE
                && (frame_lo_r[nmp_pkg::POS_CODE +: 4] == nmp_pkg::CMD_NOTCH
                    || frame_lo_r[nmp_pkg::POS_CODE +: 4] == nmp_pkg::CMD_MULTI);
    assign arrived = pos_in == dest_r;
    // Distance from the start point without direction, since stage positions are unsigned.
    assign trav = (pos_in >= start_pos_r) ? pos_in - start_pos_r : start_pos_r - pos_in;

    // Signed window test, shared by both notch channels.
    function automatic logic in_win(input logic [31:0] p, input logic [31:0] lo, input logic [31:0] hi);
        return $signed(p) >= $signed(lo) && $signed(p) <= $signed(hi);
    endfunction

    // Limit range check used for all four notch limits.
    function automatic logic lim_ok(input logic [31:0] v);
        return $signed(v) <= $signed(nmp_pkg::NOTCH_LIM_MAX) && $signed(v) >= -$signed(nmp_pkg::NOTCH_LIM_MAX);
    endfunction

    // Read mux; unmapped addresses answer zero with an error.
    // Stage windows are tested first because their ranges cover many addresses.
    always_comb begin
        rdata = 32'h0000_0000;
        rerr  = 1'b0;
        if (paddr >= nmp_pkg::OFS_STAGE_SPD && paddr < nmp_pkg::OFS_STAGE_SPD + 8'(4 * STAGES)) begin
            rdata = {14'h0000, stspd_r[paddr[5:2]]};
        end else if (paddr >= nmp_pkg::OFS_STAGE_POS && paddr < nmp_pkg::OFS_STAGE_POS + 8'(4 * STAGES)) begin
            rdata = {5'h00, stpos_r[paddr[5:2]]};
        end else if (paddr >= nmp_pkg::OFS_NOTCH_LIM && paddr < nmp_pkg::OFS_STAGE_CNT) begin
            rdata = nlim_r[2'(paddr[4:2] - 3'h3)];
        end else begin
            unique case (paddr)
                nmp_pkg::OFS_FRAME_LO:  rdata = frame_lo_r;
                nmp_pkg::OFS_FRAME_HI:  rdata = frame_hi_r;
                nmp_pkg::OFS_NOTCH_CFG: rdata = {26'h000_0000, nsel_r, 3'h0, desig_r};
                nmp_pkg::OFS_STAGE_CNT: rdata = {27'h000_0000, stage_cnt_r};
                nmp_pkg::OFS_INIT_SPD:  rdata = {14'h0000, init_spd_r};
                nmp_pkg::OFS_STATUS:    rdata = {notch_r, 1'b0, idx_r, 6'h00, speed_r};
                nmp_pkg::OFS_DEST:      rdata = dest_r;
                default:                rerr = 1'b1;
            endcase
        end
    end

    // APB answer path; read data is registered so outputs come from flops.
    // Writes raise pready too, so every access sees the same single wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r  <= rd;
            pslverr_r <= rd && rerr;
            if (rd) begin
                prdata_r <= rdata;
            end
        end
    end

    // Command frame words written by the remote controller.
    // The start history follows the stored bit, so the edge is seen one cycle after the write lands.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_lo_r   <= 32'h0000_0000;
            frame_hi_r   <= 32'h0000_0000;
            start_prev_r <= 1'b0;
        end else if (ce) begin
            start_prev_r <= frame_lo_r[nmp_pkg::BIT_START];
            if (wr && paddr == nmp_pkg::OFS_FRAME_LO) begin
                frame_lo_r <= pwdata;
            end
            if (wr && paddr == nmp_pkg::OFS_FRAME_HI) begin
                frame_hi_r <= pwdata;
            end
        end
    end

    // Parameters take effect at once; out-of-range writes are dropped to keep old values.
    // Dropping rather than clipping lets software see by read-back that a value was refused.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desig_r     <= 1'b0;
            nsel_r      <= 2'h0;
            stage_cnt_r <= nmp_pkg::STAGE_CNT_DEF;
            init_spd_r  <= nmp_pkg::SPD_DEF;
            for (int i = 0; i < 4; i++) begin
                nlim_r[i] <= 32'h0000_0000;
            end
            for (int i = 0; i < STAGES; i++) begin
                stpos_r[i] <= 27'h000_0000;
                stspd_r[i] <= nmp_pkg::SPD_DEF;
            end
        end else if (ce && wr) begin
            if (paddr == nmp_pkg::OFS_NOTCH_CFG && pwdata[31:6] == 26'h000_0000) begin
                desig_r <= pwdata[nmp_pkg::BIT_DESIG];
                nsel_r  <= pwdata[nmp_pkg::POS_NSEL +: 2];
            end
            if (paddr >= nmp_pkg::OFS_NOTCH_LIM && paddr < nmp_pkg::OFS_STAGE_CNT && lim_ok(pwdata)) begin
                nlim_r[2'(paddr[4:2] - 3'h3)] <= pwdata;
            end
            if (paddr == nmp_pkg::OFS_STAGE_CNT && pwdata <= 32'(STAGES)) begin
                stage_cnt_r <= pwdata[4:0];
            end
            if (paddr == nmp_pkg::OFS_INIT_SPD && pwdata != 0 && pwdata <= 32'(nmp_pkg::SPD_MAX)) begin
                init_spd_r <= pwdata[17:0];
            end
            // Changing stages mid-move is the controller's fault; hardware just follows.
            if (paddr >= nmp_pkg::OFS_STAGE_POS && paddr < nmp_pkg::OFS_STAGE_POS + 8'(4 * STAGES)
                && pwdata <= 32'(nmp_pkg::STAGE_POS_MAX)) begin
                stpos_r[paddr[5:2]] <= pwdata[26:0];
            end
            if (paddr >= nmp_pkg::OFS_STAGE_SPD && paddr < nmp_pkg::OFS_STAGE_SPD + 8'(4 * STAGES)
                && pwdata != 0 && pwdata <= 32'(nmp_pkg::SPD_MAX)) begin
                stspd_r[paddr[5:2]] <= pwdata[17:0];
            end
        end
    end

    // Move sequencer: latch at start, run until the destination or servo off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= IDLE;
            cmd_r       <= '0;
            dest_r      <= 32'h0000_0000;
            start_pos_r <= 32'h0000_0000;
            idx_r       <= 5'h00;
            speed_r     <= 18'h0_0000;
        end else if (ce) begin
            unique case (state_r)
                IDLE: begin
                    speed_r <= 18'h0_0000;
                    if (go) begin
                        state_r     <= MOVE;
                        cmd_r       <= {frame_lo_r[nmp_pkg::POS_CODE +: 4],
                                        frame_lo_r[nmp_pkg::BIT_INC], frame_hi_r};
                        dest_r      <= frame_lo_r[nmp_pkg::BIT_INC] ? pos_in + frame_hi_r : frame_hi_r;
                        start_pos_r <= pos_in;
                        idx_r       <= 5'h00;
                        speed_r     <= init_spd_r;
                    end
                end
                MOVE: begin
                    // At most one stage is taken per cycle, which a stepping axis never outruns.
                    if (arrived || !servo) begin
                        state_r <= IDLE;
                        speed_r <= 18'h0_0000;
                    end else if (cmd_r.code == nmp_pkg::CMD_MULTI && idx_r < stage_cnt_r
                                 && trav >= {5'h00, stpos_r[idx_r[3:0]]}) begin
                        speed_r <= stspd_r[idx_r[3:0]];
                        idx_r   <= idx_r + 5'h01;
                    end
                end
            endcase
        end
    end

    // Notch flags; designation 1 measures limits from the move start point.
    // The flags trail the position by one cycle, a limit that the remote side must allow for.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            notch_r <= 2'b00;
        end else if (ce) begin
            for (int n = 0; n < 2; n++) begin
                notch_r[n] <= state_r == MOVE && cmd_r.code == nmp_pkg::CMD_NOTCH && nsel_r[n]
                    && in_win(desig_r ? pos_in - start_pos_r : pos_in, nlim_r[2 * n], nlim_r[2 * n + 1]);
            end
        end
    end

    // Outputs are the flops themselves; busy is the one-bit state register.
    assign pready    = pready_r;
    assign prdata    = prdata_r;
    assign pslverr   = pslverr_r;
    assign speed_cmd = speed_r;
    assign dest      = dest_r;
    assign busy      = state_r == MOVE;
    assign notch     = notch_r;

    // Assertions share one clock and stay quiet while reset is held.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Steps of a move and of a bus access, named so the properties read like the sequencer.
    sequence s_launch;
        ce && go;
    endsequence
    sequence s_running;
        busy && speed_cmd == init_spd_r;
    endsequence
    sequence s_stage_hit;
        ce && busy && servo && !arrived && cmd_r.code == nmp_pkg::CMD_MULTI
            && idx_r < stage_cnt_r && trav >= {5'h00, stpos_r[idx_r[3:0]]};
    endsequence
    sequence s_access;
        ce && psel && penable && !pready;
    endsequence

    // Launch, destination and command latching.
    a_start_busy: assert property (s_launch |=> s_running) else $error("start did not launch move");
    a_no_edge_idle: assert property (ce && !busy && !start_rise |=> !busy) else $error("move without start edge");
    a_rel_dest: assert property ((s_launch and frame_lo_r[nmp_pkg::BIT_INC])
        |=> dest == $past(pos_in) + $past(frame_hi_r)) else $error("relative destination wrong");
    a_abs_dest: assert property ((s_launch and !frame_lo_r[nmp_pkg::BIT_INC])
        |=> dest == $past(frame_hi_r)) else $error("absolute destination wrong");
    a_cmd_hold: assert property (busy && $past(busy) && $past(ce) |-> $stable(cmd_r) && $stable(dest))
        else $error("command changed during move");

    // Ending a move.
    a_arrive_stop: assert property (ce && busy && arrived |=> !busy && speed_cmd == 18'h0_0000)
        else $error("move ran past its destination");
    a_servo_off: assert property (ce && busy && !servo |=> !busy) else $error("move ran without servo");
    a_idle_speed: assert property (ce && !busy ##1 ce && !busy |-> speed_cmd == 18'h0_0000)
        else $error("speed while idle");

    // Stage sequencing.
    a_stage_bound: assert property (idx_r <= stage_cnt_r || $changed(stage_cnt_r) || $past(wr))
        else $error("stage index past count");
    a_stage_step: assert property (ce && busy && $rose(idx_r[0])
        |-> speed_cmd == $past(stspd_r[0]) || idx_r != 5'h01) else $error("first stage speed not applied");
    a_stage_speed: assert property (s_stage_hit |=> speed_cmd == $past(stspd_r[idx_r[3:0]]))
        else $error("stage speed not applied at switch point");
    a_multi_only: assert property (ce && busy && cmd_r.code != nmp_pkg::CMD_MULTI |=> $stable(idx_r))
        else $error("stage advanced outside multi-speed move");
    a_speed_range: assert property (busy |-> speed_cmd != 18'h0_0000 && speed_cmd <= nmp_pkg::SPD_MAX)
        else $error("speed outside its range during move");

    // Notch outputs.
    a_notch_mode: assert property (notch != 2'b00
        |-> $past(busy) && $past(cmd_r.code) == nmp_pkg::CMD_NOTCH) else $error("notch outside notch move");
    a_notch_idle: assert property (ce && !busy |=> notch == 2'b00) else $error("notch while idle");
    a_notch_gate: assert property (ce |=> (notch & ~$past(nsel_r)) == 2'b00)
        else $error("unselected notch raised");

    // Bus answer: one wait state, and an error only together with ready.
    a_wait_state: assert property (s_access |=> pready) else $error("no ready after first access cycle");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
endmodule

// [tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [31:0] pos;
    logic [17:0] speed_cmd;
    logic [31:0] dest;
    logic        busy;
    logic [1:0]  notch;
    logic [31:0] rd;
    logic        err;
    logic [1:0]  seen_notch;
    logic [17:0] spd_q[$];
    int          mismatches = 0;
    int          compares = 0;
    // Writes with their expected read-back; out-of-range values must leave the register alone.
    logic [7:0]  t_a [10] = '{8'h1C, 8'h1C, 8'h80, 8'h80, 8'h80, 8'h40, 8'h40, 8'h08, 8'h0C, 8'h0C};
    logic [31:0] t_d [10] = '{32'h0000_0011, 32'h0000_0010, 32'h0000_0000, 32'h0003_A981, 32'h0003_A980,
                              32'h05F5_E100, 32'h05F5_E0FF, 32'h0000_0031, 32'hFA0A_1F00, 32'hFA0A_1F01};
    logic [31:0] t_e [10] = '{32'h0000_0000, 32'h0000_0010, 32'h0000_5DC0, 32'h0000_5DC0, 32'h0003_A980,
                              32'h0000_0000, 32'h05F5_E0FF, 32'h0000_0031, 32'h0000_0000, 32'hFA0A_1F01};

    always #2.5 pclk = ~pclk;

    notch_multispeed_positioning notch_multispeed_positioning_inst (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pos_in(pos), .speed_cmd(speed_cmd), .dest(dest), .busy(busy), .notch(notch));

    axis_model axis_model_inst (.pclk(pclk), .presetn(presetn), .busy(busy), .dest(dest), .pos(pos));

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            $display("BAD at %0t: no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // Controller order: code cleared with servo on, target, mode fields, then start rises.
    task automatic move(input logic [31:0] lo, input logic [31:0] target);
        apb(1'b1, nmp_pkg::OFS_FRAME_LO, 32'h0000_0002);
        apb(1'b1, nmp_pkg::OFS_FRAME_HI, target);
        apb(1'b1, nmp_pkg::OFS_FRAME_LO, lo);
        apb(1'b1, nmp_pkg::OFS_FRAME_LO, lo | 32'h0000_0001);
    endtask

    // Records each new nonzero speed and any notch pulse until the move ends.
    task automatic watch();
        int n;
        n = 0;
        spd_q.delete();
        seen_notch = 2'b00;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
            seen_notch |= notch;
            if (speed_cmd != 0 && (spd_q.size() == 0 || spd_q[$] != speed_cmd)) spd_q.push_back(speed_cmd);
        end
    endtask

    // A hang anywhere ends the run well after the few hundred cycles the tests need.
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk(nmp_pkg::OFS_INIT_SPD, {14'h0000, nmp_pkg::SPD_DEF});
        rchk(nmp_pkg::OFS_STAGE_SPD + 8'h3C, {14'h0000, nmp_pkg::SPD_DEF});
        rchk(nmp_pkg::OFS_STAGE_CNT, 32'h0000_0000);
        rchk(nmp_pkg::OFS_STAGE_POS + 8'h3C, 32'h0000_0000);
        rchk(nmp_pkg::OFS_NOTCH_CFG, 32'h0000_0000);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, t_a[i], t_d[i]);
            rchk(t_a[i], t_e[i]);
        end
        // Two stages: 50 until 4 steps, 100 until 8 steps, then 200; stage three must stay unused.
        apb(1'b1, nmp_pkg::OFS_STAGE_CNT, 32'h0000_0002);
        apb(1'b1, nmp_pkg::OFS_STAGE_POS, 32'h0000_0004);
        apb(1'b1, nmp_pkg::OFS_STAGE_POS + 8'h04, 32'h0000_0008);
        apb(1'b1, nmp_pkg::OFS_STAGE_SPD, 32'h0000_0064);
        apb(1'b1, nmp_pkg::OFS_STAGE_SPD + 8'h04, 32'h0000_00C8);
        apb(1'b1, nmp_pkg::OFS_INIT_SPD, 32'h0000_0032);
        move(32'h0000_0402, 32'h0000_0014);
        watch();
        chk(spd_q.size(), 32'h0000_0003);
        chk(spd_q[0], 32'h0000_0032);
        chk(spd_q[1], 32'h0000_0064);
        chk(spd_q[2], 32'h0000_00C8);
        chk(pos, 32'h0000_0014);
        rchk(nmp_pkg::OFS_DEST, 32'h0000_0014);
        // Relative move from 20 by -10 through notch windows 12..14 and 15..16; target changes are ignored.
        apb(1'b1, nmp_pkg::OFS_NOTCH_CFG, 32'h0000_0030);
        apb(1'b1, nmp_pkg::OFS_NOTCH_LIM, 32'h0000_000C);
        apb(1'b1, nmp_pkg::OFS_NOTCH_LIM + 8'h04, 32'h0000_000E);
        apb(1'b1, nmp_pkg::OFS_NOTCH_LIM + 8'h08, 32'h0000_000F);
        apb(1'b1, nmp_pkg::OFS_NOTCH_LIM + 8'h0C, 32'h0000_0010);
        move(32'h0100_0302, 32'hFFFF_FFF6);
        apb(1'b1, nmp_pkg::OFS_FRAME_HI, 32'h0000_0064);
        watch();
        chk(seen_notch, 2'b11);
        chk(dest, 32'h0000_000A);
        chk(spd_q.size(), 32'h0000_0001);
        chk(spd_q[0], 32'h0000_0032);
        // An unknown code, then a code with no new start edge, must both be ignored.
        move(32'h0000_0502, 32'h0000_0005);
        watch();
        apb(1'b1, nmp_pkg::OFS_FRAME_LO, 32'h0000_0403);
        watch();
        chk(busy, 1'b0);
        chk(pos, 32'h0000_000A);
        // Servo dropped during a move to 40 aborts it four steps out from 10.
        move(32'h0000_0302, 32'h0000_0028);
        apb(1'b1, nmp_pkg::OFS_FRAME_LO, 32'h0000_0301);
        watch();
        chk(busy, 1'b0);
        chk(pos, 32'h0000_000E);
        chk(dest, 32'h0000_0028);
        finish_test();
    end
endmodule
